// file: logic/qu_consts.vh
// constants for the four-channel serial port block
`ifndef QU_CONSTS_VH
`define QU_CONSTS_VH
// =====================================================
// register map (byte addresses, 8-bit address space)
`define QU_ADDR_W 8
`define QU_GLOBAL_BIT 7
`define QU_CH_HI 6
`define QU_CH_LO 5
`define QU_REG_HI 4
`define QU_REG_LO 2
`define QU_REG_DATA 3'h0
`define QU_REG_LINE_CTRL 3'h1
`define QU_REG_MODEM_CTRL 3'h2
`define QU_REG_MODEM_STAT 3'h3
`define QU_REG_LINE_STAT 3'h4
`define QU_REG_DIVISOR 3'h5
`define QU_REG_HOST_SEL 3'h0
// =====================================================
// line control fields
`define QU_LC_WLEN_HI 1
`define QU_LC_WLEN_LO 0
`define QU_LC_STOP2 2
`define QU_LC_PAR_EN 3
`define QU_LC_PAR_EVEN 4
`define QU_LC_TX_EN 5
`define QU_LC_LOOP 6
`define QU_LC_RESET 8'h20
// =====================================================
// modem control / status fields
`define QU_MC_DTR 0
`define QU_MC_RTS 1
`define QU_MC_IRQ_EN 3
`define QU_MC_RESET 8'h00
`define QU_MS_RI_EDGE 2
`define QU_MS_CTS 4
`define QU_MS_DSR 5
`define QU_MS_RI 6
`define QU_MS_CD 7
// =====================================================
// line status fields
`define QU_LS_RX_READY 0
`define QU_LS_OVERRUN 1
`define QU_LS_PAR_ERR 2
`define QU_LS_FRAME_ERR 3
`define QU_LS_TX_ROOM 5
`define QU_LS_TX_IDLE 6
// =====================================================
// baud and framing
`define QU_DIV_RESET 16'h0001
`define QU_OVERSAMPLE 4'hf
`define QU_HALF_BIT 4'h7
`define QU_WLEN_BASE 4'h5
`define QU_RX_SR_W 4'ha
// =====================================================
// bus responses
`define QU_RESP_OKAY 2'b00
`define QU_RESP_SLVERR 2'b10
`endif

// file: logic/qu_top.v
// four-channel serial port: channel select, modem pins, framing, fifos, AXI4-Lite registers
// How it works
// - ring input rising to 1 sets a sticky interrupt condition for that channel.
// - modem control bit 1 set drives that channel's RTS output low.
// - after reset every RTS output sits high.
// - RTS is a software modem line only, never touching transmit or receive.
// - transmit pin stays high in reset, when idle, and when transmitter disabled.
// - loopback ignores receive pin and feeds own transmit stream to receiver.
// - transmitter adds start and stop bits; receiver rebuilds parallel bytes.
// - optional parity bit appended on transmit and checked on receive.
// - each channel has its own 16-byte transmit and receive fifo.
// - bus-style pin high picks four-select mode, low picks single-select mode.
// - four-select mode: a low select picks its channel; all high picks none.
// - single-select mode: address bits 00..11 pick A..D; select high picks none.
// - the two channel address bits are ignored in four-select mode.
// - four-select mode: mode pin and modem bit 3 decide interrupt output gating.
// - mode pin low gives bit 3 control of enable; high keeps outputs driven.
// - modem control bit 0 drives DTR low when 1, high when 0.
// - CTS pin state readable in modem status bit 4.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "qu_consts.vh"

// =====================================================
// fifo
module qu_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  always @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      // pointers wrap by hand so depth need not be a power of two
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// =====================================================
// top
module qu_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire bus_style_pin,
  input wire channel_a_select_n,
  input wire channel_b_select_n,
  input wire channel_c_select_n,
  input wire channel_d_select_n,
  input wire single_select_n,
  input wire channel_addr_high,
  input wire channel_addr_low,
  input wire irq_output_mode_pin,
  output reg [3:0] channel_selected,
  input wire [3:0] rx_pin,
  output reg [3:0] tx_pin,
  input wire [3:0] cts_n,
  input wire [3:0] dsr_n,
  input wire [3:0] ri_n,
  input wire [3:0] cd_n,
  output reg [3:0] rts_n,
  output reg [3:0] dtr_n,
  output reg [3:0] irq,
  output reg [3:0] irq_oe
);
  // =====================================================
  // pin synchronisers (first stage read only by second)
  reg [8:0] host_s1;
  reg [8:0] host_s2;
  reg [19:0] modem_s1;
  reg [19:0] modem_s2;
  always @(posedge aclk) begin
    host_s1 <= {irq_output_mode_pin, channel_addr_high, channel_addr_low, single_select_n,
      channel_d_select_n, channel_c_select_n, channel_b_select_n, channel_a_select_n,
      bus_style_pin};
    host_s2 <= host_s1;
    modem_s1 <= {cd_n, ri_n, dsr_n, cts_n, rx_pin};
    modem_s2 <= modem_s1;
  end
  wire style_four = host_s2[0];
  wire [3:0] sel_n = host_s2[4:1];
  wire mode_pin = host_s2[8];
  wire [3:0] rx_s = modem_s2[3:0];
  wire [3:0] cts_s = modem_s2[7:4];
  wire [3:0] dsr_s = modem_s2[11:8];
  wire [3:0] ri_s = modem_s2[15:12];
  wire [3:0] cd_s = modem_s2[19:16];

  // =====================================================
  // channel select decode
  function [3:0] decode_sel;
    input style;
    input [3:0] cs_n;
    input one_cs_n;
    input [1:0] addr;
    begin
      if (style) begin
        decode_sel = ~cs_n;
      end else if (!one_cs_n) begin
        decode_sel = 4'h1 << addr;
      end else begin
        decode_sel = 4'h0;
      end
    end
  endfunction

  // =====================================================
  // control registers written by software
  reg [7:0] line_ctrl [0:3];
  reg [7:0] modem_ctrl [0:3];
  reg [15:0] divisor [0:3];
  wire [7:0] modem_stat [0:3];
  wire [7:0] line_stat [0:3];
  wire [7:0] rx_head [0:3];
  wire [3:0] tx_room;
  wire [3:0] irq_cond;

  // =====================================================
  // AXI4-Lite slave
  reg [7:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg aw_have;
  reg w_have;
  wire wr_go = aw_have && w_have && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire [1:0] wr_ch = wr_addr[`QU_CH_HI:`QU_CH_LO];
  wire [2:0] wr_reg = wr_addr[`QU_REG_HI:`QU_REG_LO];
  wire wr_glob = wr_addr[`QU_GLOBAL_BIT];
  wire [1:0] rd_ch = s_axi_araddr[`QU_CH_HI:`QU_CH_LO];
  wire [2:0] rd_reg = s_axi_araddr[`QU_REG_HI:`QU_REG_LO];
  wire rd_glob = s_axi_araddr[`QU_GLOBAL_BIT];
  wire wr_data_hit = wr_go && !wr_glob && wr_reg == `QU_REG_DATA && wr_strb[0];
  wire rd_local = rd_go && !rd_glob;
  wire [3:0] ch_wr_onehot = 4'h1 << wr_ch;
  wire [3:0] ch_rd_onehot = 4'h1 << rd_ch;
  wire [3:0] tx_push = wr_data_hit ? ch_wr_onehot : 4'h0;
  wire [3:0] rx_pop = (rd_local && rd_reg == `QU_REG_DATA) ? ch_rd_onehot : 4'h0;
  wire [3:0] ms_read = (rd_local && rd_reg == `QU_REG_MODEM_STAT) ? ch_rd_onehot : 4'h0;
  wire [3:0] ls_read = (rd_local && rd_reg == `QU_REG_LINE_STAT) ? ch_rd_onehot : 4'h0;
  integer i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `QU_RESP_OKAY;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        line_ctrl[i] <= `QU_LC_RESET;
        modem_ctrl[i] <= `QU_MC_RESET;
        divisor[i] <= `QU_DIV_RESET;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_glob || wr_reg > `QU_REG_DIVISOR) ? `QU_RESP_SLVERR : `QU_RESP_OKAY;
        if (!wr_glob && wr_strb[0]) begin
          case (wr_reg)
            `QU_REG_LINE_CTRL: line_ctrl[wr_ch] <= wr_data[7:0];
            `QU_REG_MODEM_CTRL: modem_ctrl[wr_ch] <= wr_data[7:0];
            `QU_REG_DIVISOR: divisor[wr_ch][7:0] <= wr_data[7:0];
            default: ;
          endcase
        end
        if (!wr_glob && wr_strb[1] && wr_reg == `QU_REG_DIVISOR) begin
          divisor[wr_ch][15:8] <= wr_data[15:8];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `QU_RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `QU_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (rd_glob) begin
          if (rd_reg == `QU_REG_HOST_SEL && !rd_ch[0] && !rd_ch[1]) begin
            s_axi_rdata <= {27'h0, style_four, channel_selected};
          end else begin
            s_axi_rresp <= `QU_RESP_SLVERR;
          end
        end else begin
          case (rd_reg)
            `QU_REG_DATA: s_axi_rdata <= {24'h0, rx_head[rd_ch]};
            `QU_REG_LINE_CTRL: s_axi_rdata <= {24'h0, line_ctrl[rd_ch]};
            `QU_REG_MODEM_CTRL: s_axi_rdata <= {24'h0, modem_ctrl[rd_ch]};
            `QU_REG_MODEM_STAT: s_axi_rdata <= {24'h0, modem_stat[rd_ch]};
            `QU_REG_LINE_STAT: s_axi_rdata <= {24'h0, line_stat[rd_ch]};
            `QU_REG_DIVISOR: s_axi_rdata <= {16'h0, divisor[rd_ch]};
            default: s_axi_rresp <= `QU_RESP_SLVERR;
          endcase
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // =====================================================
  // host pins: selected channel and interrupt outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_selected <= 4'h0;
      irq <= 4'h0;
    end else begin
      channel_selected <= decode_sel(style_four, sel_n, host_s2[5], host_s2[7:6]);
      irq <= irq_cond;
    end
  end

  // =====================================================
  // per-channel serial engines
  localparam TX_IDLE = 2'b01;
  localparam TX_SHIFT = 2'b10;
  localparam RX_IDLE = 3'b001;
  localparam RX_START = 3'b010;
  localparam RX_BITS = 3'b100;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      reg [15:0] div_cnt;
      reg tick;
      reg [1:0] tx_state;
      reg [3:0] tx_sub;
      reg [3:0] tx_left;
      reg [11:0] tx_sr;
      reg [2:0] rx_state;
      reg [3:0] rx_sub;
      reg [3:0] rx_left;
      reg [9:0] rx_sr;
      reg rx_push;
      reg [7:0] rx_byte;
      reg ri_prev;
      reg ri_edge;
      reg overrun;
      reg par_err;
      reg frame_err;
      wire [7:0] lc = line_ctrl[g];
      wire [3:0] wlen = `QU_WLEN_BASE + {2'b00, lc[`QU_LC_WLEN_HI:`QU_LC_WLEN_LO]};
      wire [7:0] wmask = 8'hff >> (4'h8 - wlen);
      wire tx_valid;
      wire [7:0] tx_byte;
      wire rx_ready_in;
      wire rx_valid;
      wire tx_take = (tx_state == TX_IDLE) && tx_valid && lc[`QU_LC_TX_EN];
      wire [7:0] tx_d = tx_byte & wmask;
      wire tx_par = (^tx_d) ^ !lc[`QU_LC_PAR_EVEN];
      wire tx_line = (tx_state == TX_SHIFT) ? tx_sr[0] : 1'b1;
      wire rx_line = lc[`QU_LC_LOOP] ? tx_line : rx_s[g];
      wire [3:0] rx_bits = wlen + {3'b000, lc[`QU_LC_PAR_EN]} + 4'h1;
      wire [9:0] rx_al = rx_sr >> (`QU_RX_SR_W - rx_bits);
      wire [7:0] rx_d = rx_al[7:0] & wmask;
      wire rx_par_bit = rx_al[wlen];
      wire rx_stop_bit = rx_al[rx_bits - 4'h1];

      qu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) tx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(tx_push[g]),
        .in_ready(tx_room[g]),
        .in_data(wr_data[7:0]),
        .out_valid(tx_valid),
        .out_ready(tx_take),
        .out_data(tx_byte)
      );
      qu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) rx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(rx_push),
        .in_ready(rx_ready_in),
        .in_data(rx_byte),
        .out_valid(rx_valid),
        .out_ready(rx_pop[g]),
        .out_data(rx_head[g])
      );

      // 16x oversample enable; divisor 0 treated as 1
      always @(posedge aclk) begin
        if (!aresetn || div_cnt <= 16'h0001) begin
          div_cnt <= divisor[g];
          tick <= aresetn;
        end else begin
          div_cnt <= div_cnt - 16'h0001;
          tick <= 1'b0;
        end
      end

      always @(posedge aclk) begin
        if (!aresetn) begin
          tx_state <= TX_IDLE;
          tx_sub <= 4'h0;
          tx_left <= 4'h0;
          tx_sr <= 12'hfff;
        end else begin
          case (tx_state)
            TX_IDLE: begin
              if (tx_take) begin
                // start, data, optional parity, then stop bits
                tx_sr <= lc[`QU_LC_PAR_EN]
                  ? ({3'b111, tx_d | ~wmask, 1'b0} & ~(12'h001 << (wlen + 4'h1)))
                    | ({11'h0, tx_par} << (wlen + 4'h1))
                  : {3'b111, tx_d | ~wmask, 1'b0};
                tx_left <= wlen + {3'b000, lc[`QU_LC_PAR_EN]} + {3'b000, lc[`QU_LC_STOP2]} + 4'h2;
                tx_sub <= 4'h0;
                tx_state <= TX_SHIFT;
              end
            end
            TX_SHIFT: begin
              if (tick) begin
                tx_sub <= tx_sub + 4'h1;
                if (tx_sub == `QU_OVERSAMPLE) begin
                  tx_sr <= {1'b1, tx_sr[11:1]};
                  tx_left <= tx_left - 4'h1;
                  if (tx_left == 4'h1) begin
                    tx_state <= TX_IDLE;
                  end
                end
              end
            end
            default: tx_state <= TX_IDLE;
          endcase
        end
      end

      always @(posedge aclk) begin
        if (!aresetn) begin
          rx_state <= RX_IDLE;
          rx_sub <= 4'h0;
          rx_left <= 4'h0;
          rx_sr <= 10'h000;
          rx_push <= 1'b0;
          rx_byte <= 8'h00;
          overrun <= 1'b0;
          par_err <= 1'b0;
          frame_err <= 1'b0;
        end else begin
          rx_push <= 1'b0;
          // a read clears the sticky errors, but a fresh error wins
          if (ls_read[g]) begin
            overrun <= 1'b0;
            par_err <= 1'b0;
            frame_err <= 1'b0;
          end
          case (rx_state)
            RX_IDLE: begin
              if (!rx_line) begin
                rx_sub <= 4'h0;
                rx_state <= RX_START;
              end
            end
            RX_START: begin
              if (tick) begin
                rx_sub <= rx_sub + 4'h1;
                if (rx_sub == `QU_HALF_BIT) begin
                  rx_sub <= 4'h0;
                  rx_left <= rx_bits;
                  rx_state <= rx_line ? RX_IDLE : RX_BITS;
                end
              end
            end
            RX_BITS: begin
              if (tick) begin
                rx_sub <= rx_sub + 4'h1;
                if (rx_sub == `QU_OVERSAMPLE) begin
                  rx_sr <= {rx_line, rx_sr[9:1]};
                  rx_left <= rx_left - 4'h1;
                  if (rx_left == 4'h1) begin
                    rx_state <= RX_IDLE;
                  end
                end
              end
            end
            default: rx_state <= RX_IDLE;
          endcase
          // one cycle after the last sample the aligned frame is checked
          if (rx_state == RX_IDLE && rx_left == 4'h0 && rx_sub == 4'h0 && rx_sr != 10'h000) begin
            rx_sr <= 10'h000;
          end
          if (rx_state == RX_BITS && tick && rx_sub == `QU_OVERSAMPLE && rx_left == 4'h1) begin
            rx_left <= 4'h0;
          end
          if (rx_state == RX_IDLE && rx_left == 4'h0 && rx_sr != 10'h000) begin
            rx_byte <= rx_d;
            rx_push <= rx_ready_in;
            if (!rx_ready_in) overrun <= 1'b1;
            if (lc[`QU_LC_PAR_EN] && (rx_par_bit != ((^rx_d) ^ !lc[`QU_LC_PAR_EVEN]))) begin
              par_err <= 1'b1;
            end
            if (!rx_stop_bit) frame_err <= 1'b1;
          end
        end
      end

      always @(posedge aclk) begin
        if (!aresetn) begin
          ri_prev <= 1'b1;
          ri_edge <= 1'b0;
          tx_pin[g] <= 1'b1;
          rts_n[g] <= 1'b1;
          dtr_n[g] <= 1'b1;
          irq_oe[g] <= 1'b0;
        end else begin
          ri_prev <= ri_s[g];
          if (ri_s[g] && !ri_prev) begin
            ri_edge <= 1'b1;
          end else if (ms_read[g]) begin
            ri_edge <= 1'b0;
          end
          tx_pin[g] <= lc[`QU_LC_LOOP] ? 1'b1 : tx_line;
          rts_n[g] <= !modem_ctrl[g][`QU_MC_RTS];
          dtr_n[g] <= !modem_ctrl[g][`QU_MC_DTR];
          // single-select mode keeps interrupt outputs driven
          irq_oe[g] <= !style_four || mode_pin || modem_ctrl[g][`QU_MC_IRQ_EN];
        end
      end

      assign modem_stat[g] = {!cd_s[g], !ri_s[g], !dsr_s[g], !cts_s[g], 1'b0, ri_edge, 2'b00};
      assign line_stat[g] = {1'b0, tx_state == TX_IDLE && !tx_valid, tx_room[g], 1'b0,
        frame_err, par_err, overrun, rx_valid};
      assign irq_cond[g] = ri_edge || rx_valid || par_err || frame_err || overrun;
    end
  endgenerate
endmodule
`default_nettype wire

// file: testbench/qu_top_sva.sv
// port checker for the four-channel serial block
`timescale 1ns/1ps
`default_nettype none
module qu_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_style_pin,
  input wire logic channel_a_select_n,
  input wire logic channel_b_select_n,
  input wire logic channel_c_select_n,
  input wire logic channel_d_select_n,
  input wire logic single_select_n,
  input wire logic channel_addr_high,
  input wire logic channel_addr_low,
  input wire logic irq_output_mode_pin,
  input wire logic [3:0] channel_selected,
  input wire logic [3:0] tx_pin,
  input wire logic [3:0] rts_n,
  input wire logic [3:0] dtr_n,
  input wire logic [3:0] ri_n,
  input wire logic [3:0] irq,
  input wire logic [3:0] irq_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire [3:0] cs_n = {channel_d_select_n, channel_c_select_n, channel_b_select_n,
    channel_a_select_n};
  wire [1:0] addr = {channel_addr_high, channel_addr_low};
  // =========
  // pins held long enough to pass the synchronisers
  sequence s_four(logic [3:0] c);
    (bus_style_pin && cs_n == c)[*6];
  endsequence
  sequence s_single(logic sel);
    (!bus_style_pin && single_select_n == sel && $stable(addr))[*6];
  endsequence
  property p_out_reset;
    $rose(aresetn) |-> tx_pin == 4'hf && rts_n == 4'hf && dtr_n == 4'hf;
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("pins not idle after reset");
  property p_four_none;
    s_four(4'hf) |-> channel_selected == 4'h0;
  endproperty
  a_four_none: assert property (p_four_none) else $error("channel picked with no select");
  property p_four_pick;
    s_four(4'he) |-> channel_selected == 4'h1;
  endproperty
  a_four_pick: assert property (p_four_pick) else $error("select a not honoured");
  property p_single_pick;
    s_single(1'b0) |-> channel_selected == (4'h1 << addr);
  endproperty
  a_single_pick: assert property (p_single_pick) else $error("address decode wrong");
  property p_single_none;
    s_single(1'b1) |-> channel_selected == 4'h0;
  endproperty
  a_single_none: assert property (p_single_none) else $error("channel picked unselected");
  property p_oe_pin;
    (bus_style_pin && irq_output_mode_pin)[*6] |-> irq_oe == 4'hf;
  endproperty
  a_oe_pin: assert property (p_oe_pin) else $error("irq outputs not driven");
  property p_oe_single;
    (!bus_style_pin)[*6] |-> irq_oe == 4'hf;
  endproperty
  a_oe_single: assert property (p_oe_single) else $error("irq outputs gated");
  property p_ring;
    $rose(ri_n[0]) |-> ##[1:8] irq[0];
  endproperty
  a_ring: assert property (p_ring) else $error("ring release gave no interrupt");
endmodule
bind qu_top qu_top_sva qu_top_sva_inst (.aclk, .aresetn, .bus_style_pin, .channel_a_select_n,
  .channel_b_select_n, .channel_c_select_n, .channel_d_select_n, .single_select_n,
  .channel_addr_high, .channel_addr_low, .irq_output_mode_pin, .channel_selected, .tx_pin,
  .rts_n, .dtr_n, .ri_n, .irq, .irq_oe);
`default_nettype wire

// file: testbench/qu_far_model.sv
// modem and serial line model at the far side
`timescale 1ns/1ps
`default_nettype none
module qu_far_model (
  input wire logic [3:0] tx_pin,
  input wire logic cut,
  input wire logic [3:0] ready_on,
  input wire logic [3:0] ring,
  output logic [3:0] rx_pin,
  output logic [3:0] cts_n,
  output logic [3:0] dsr_n,
  output logic [3:0] ri_n,
  output logic [3:0] cd_n
);
  // cable wraps tx to rx; a cut line sits low like a break
  assign rx_pin = cut ? 4'h0 : tx_pin;
  assign cts_n = ~ready_on;
  assign dsr_n = ~ready_on;
  assign cd_n = ~ready_on;
  assign ri_n = ~ring;
endmodule
`default_nettype wire

// file: testbench/test_qu_top.sv
// self-checking bench for the four-channel serial block
`timescale 1ns/1ps
`default_nettype none
`include "qu_consts.vh"
module test_qu_top;
  logic aclk, aresetn, cut, bus_style_pin, single_select_n, irq_output_mode_pin;
  logic channel_addr_high, channel_addr_low;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] cs_n, channel_selected, rx_pin, tx_pin, cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n;
  logic [3:0] irq, irq_oe, ready_on, ring;
  logic [31:0] lcs [3] = '{32'h26, 32'h3b, 32'h63};
  logic [7:0] dat [3] = '{8'h5a, 8'h3c, 8'ha5};
  int failures, checks_done, cyc, i;
  qu_top qu_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_style_pin,
    .channel_a_select_n(cs_n[0]), .channel_b_select_n(cs_n[1]),
    .channel_c_select_n(cs_n[2]), .channel_d_select_n(cs_n[3]), .single_select_n,
    .channel_addr_high, .channel_addr_low, .irq_output_mode_pin, .channel_selected,
    .rx_pin, .tx_pin, .cts_n, .dsr_n, .ri_n, .cd_n, .rts_n, .dtr_n, .irq, .irq_oe);
  qu_far_model qu_far_model_inst (.tx_pin, .cut, .ready_on, .ring, .rx_pin, .cts_n,
    .dsr_n, .ri_n, .cd_n);
  // =========
  // tasks
  function automatic logic [7:0] ra(int c, logic [2:0] r);
    return {1'b0, c[1:0], r, 2'b00};
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bit ad, dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      dd = dd | s_axi_wready;
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    rr = s_axi_bresp;
    @(posedge aclk);
  endtask
  task automatic rd(logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // =========
  // clock, watchdog, tests
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    {aresetn, cut, single_select_n, irq_output_mode_pin, ready_on, ring} = 12'h200;
    {channel_addr_high, channel_addr_low, cs_n, bus_style_pin} = 7'h1f;
    {cyc, failures, checks_done} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    wt(16);
    aresetn <= 1'b1;
    wt(1);
    rd(ra(0, `QU_REG_LINE_CTRL));
    chk("line_ctrl", rv, 32'h20);
    chk("rts_n", rts_n, 4'hf);
    chk("tx_pin", tx_pin, 4'hf);
    for (i = 0; i < 4; i++) begin
      wr(ra(i, `QU_REG_MODEM_CTRL), 32'h3);
      wt(2);
      chk("rts_n", rts_n[i], 1'b0);
      chk("dtr_n", dtr_n[i], 1'b0);
      wr(ra(i, `QU_REG_MODEM_CTRL), 32'h0);
      wt(2);
      chk("rts_n", rts_n[i], 1'b1);
      chk("dtr_n", dtr_n[i], 1'b1);
    end
    for (i = 1; i >= 0; i--) begin
      ready_on <= {4{i[0]}};
      wt(6);
      rd(ra(0, `QU_REG_MODEM_STAT));
      chk("cts", rv[`QU_MS_CTS], i[0]);
    end
    $display("done modem");
    for (i = 0; i < 5; i++) begin
      cs_n <= (i < 4) ? ~(4'h1 << i) : 4'hf;
      {channel_addr_high, channel_addr_low} <= ~i[1:0];
      wt(6);
      chk("selected", channel_selected, (i < 4) ? 4'h1 << i : 4'h0);
    end
    bus_style_pin <= 1'b0;
    single_select_n <= 1'b0;
    for (i = 0; i < 4; i++) begin
      {channel_addr_high, channel_addr_low} <= i[1:0];
      wt(6);
      chk("selected", channel_selected, 4'h1 << i);
    end
    rd(8'h80);
    chk("host_sel", rv[4:0], 5'h08);
    single_select_n <= 1'b1;
    wt(6);
    chk("selected", channel_selected, 4'h0);
    bus_style_pin <= 1'b1;
    for (i = 0; i < 3; i++) begin
      irq_output_mode_pin <= (i == 2);
      wr(ra(0, `QU_REG_MODEM_CTRL), (i == 1) ? 32'h8 : 32'h0);
      wt(6);
      chk("irq_oe", irq_oe[0], i != 0);
    end
    irq_output_mode_pin <= 1'b0;
    chk("irq", irq[0], 1'b0);
    ring <= 4'h1;
    wt(6);
    chk("irq", irq[0], 1'b0);
    ring <= 4'h0;
    wt(8);
    chk("irq", irq[0], 1'b1);
    $display("done select");
    // rts held asserted: the serial path must not care
    wr(ra(0, `QU_REG_MODEM_CTRL), 32'h2);
    for (i = 0; i < 3; i++) begin
      wr(ra(0, `QU_REG_LINE_CTRL), lcs[i]);
      cut <= (i == 2);
      wr(ra(0, `QU_REG_DATA), dat[i]);
      wt(8);
      chk("start_bit", tx_pin[0], i == 2);
      wt(250);
      rd(ra(0, `QU_REG_DATA));
      chk("rx_data", rv[7:0], dat[i]);
      rd(ra(0, `QU_REG_LINE_STAT));
      chk("rx_errors", rv[3:1], 3'h0);
    end
    $display("done serial");
    wr(ra(1, `QU_REG_LINE_CTRL), 32'h03);
    for (i = 0; i < 16; i++) begin
      wr(ra(1, `QU_REG_DATA), i);
      rd(ra(1, `QU_REG_LINE_STAT));
      chk("tx_room", rv[`QU_LS_TX_ROOM], i < 15);
    end
    rd(8'h18);
    chk("resp", rr, `QU_RESP_SLVERR);
    wr(8'h1c, 32'h1);
    chk("resp", rr, `QU_RESP_SLVERR);
    $display("done fifo");
    wrap_up();
  end
endmodule
`default_nettype wire
